// file: hbc_map.svh
// register offsets, field positions and timing figures of the h-bridge controller
// assumes inclusion by the package and the design modules; guarded against repeats
`ifndef HBC_MAP_SVH
`define HBC_MAP_SVH

`define HBC_OFF_CTRL      12'h000
`define HBC_OFF_DUTY      12'h004
`define HBC_OFF_PERIOD    12'h008
`define HBC_OFF_STATUS    12'h00C
`define HBC_OFF_IRQ_EN    12'h010
`define HBC_OFF_IRQ_CLR   12'h014
`define HBC_OFF_PINS      12'h018

`define HBC_CTRL_EN       0
`define HBC_CTRL_MODE     1
`define HBC_CTRL_SIGN     2
`define HBC_CTRL_BRAKE    3
`define HBC_CTRL_COAST    4
`define HBC_CTRL_W        5

`define HBC_ST_WARN       0
`define HBC_ST_WARN_CLR   1
`define HBC_ST_W          2

`define HBC_PERIOD_RST    16'h03E8
`define HBC_DUTY_RST      16'h01F4

`define HBC_CLK_NS        25
`define HBC_SEP_NS        1000
`define HBC_GAP_NS        500
`define HBC_SEP_CYC       ((`HBC_SEP_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`define HBC_GAP_CYC       ((`HBC_GAP_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)

`endif

// file: hbc_pkg.sv
// types shared by the h-bridge controller files
// assumes hbc_map.svh in the include path
package hbc_pkg;
	`include "hbc_map.svh"

	typedef struct packed {
		logic pwm;   // pulse / magnitude pin
		logic dir;   // rotation sense pin
		logic brake; // brake pin
	} hbc_pins_s;

	typedef enum logic [1:0] {
		HBC_IDLE,
		HBC_HOLD
	} hbc_sep_e;
endpackage

// file: hbc_sep.sv
// edge spacer: lets one pin change at a time, then waits before the next
// assumes wanted levels come from the pwm generator in the same clock domain
`timescale 1ns/10ps
`include "hbc_map.svh"
module hbc_sep
	import hbc_pkg::*;
#(
	parameter int SEP_CYC = `HBC_SEP_CYC
) (
	input  wire logic      mclk,    // system clock
	input  wire logic      resetn,  // async reset, active low
	input  wire hbc_pins_s want,    // wanted pin levels
	input  wire hbc_pins_s safe,    // unused; reset loads all pins low
	output hbc_pins_s      pins_reg // spaced pin levels
);
	localparam int CW = $clog2(SEP_CYC + 1);

	hbc_sep_e        state_reg;
	logic [CW-1:0]   cnt_reg;

	// one pin per step, priority pwm, dir, brake; after a change hold SEP_CYC cycles
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pins_reg  <= '0;
			state_reg <= HBC_IDLE;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				HBC_IDLE: begin
					if (want.pwm != pins_reg.pwm) begin
						pins_reg.pwm <= want.pwm;
						state_reg    <= HBC_HOLD;
						cnt_reg      <= CW'(SEP_CYC - 1);
					end else if (want.dir != pins_reg.dir) begin
						pins_reg.dir <= want.dir;
						state_reg    <= HBC_HOLD;
						cnt_reg      <= CW'(SEP_CYC - 1);
					end else if (want.brake != pins_reg.brake) begin
						pins_reg.brake <= want.brake;
						state_reg      <= HBC_HOLD;
						cnt_reg        <= CW'(SEP_CYC - 1);
					end
				end
				HBC_HOLD: begin
					// 1 us from one edge covers the 500 ns gap after the edge completes
					if (cnt_reg == '0) begin
						state_reg <= HBC_IDLE;
					end else begin
						cnt_reg <= cnt_reg - CW'(1);
					end
				end
				default: begin
					state_reg <= HBC_IDLE;
				end
			endcase
		end
	end
endmodule

// file: hbc_top.sv
// apb controller driving an h-bridge driver's pwm, direction and brake pins
// assumes apb from one master in the mclk domain; the warning pin has an external pull-up
// What this block does
// - to brake, drive brake high and pwm high; direction picks the shorting pair.
// - anti-phase: modulated signal on direction, pwm held high; half duty is zero.
// - sign/magnitude: sign on direction, duty on pwm; steady low is zero.
// - changes on the three pins are spaced at least 1 us, never aligned.
// - leave at least 500 ns after one transition ends before the next.
`timescale 1ns/10ps
`include "hbc_map.svh"
module hbc_top
	import hbc_pkg::*;
#(
	parameter int PW = 16 // period and duty width
) (
	input  wire logic        mclk,         // 40 MHz clock
	input  wire logic        resetn,       // async reset, active low
	input  wire logic        psel,         // apb select
	input  wire logic        penable,      // apb access phase
	input  wire logic        pwrite,       // apb direction
	input  wire logic [11:0] paddr,        // apb byte address
	input  wire logic [31:0] pwdata,       // apb write data
	output logic [31:0]      prdata,       // apb read data
	output logic             pready,       // apb ready
	output logic             pslverr,      // apb error
	output logic             drv_pwm,      // to driver pwm pin
	output logic             drv_dir,      // to driver direction pin
	output logic             drv_brake,    // to driver brake pin
	input  wire logic        warn_n_in,    // warning pin level, low = hot
	output logic             warn_n_out,   // never driven low by us
	output logic             warn_n_oe,    // never drives the shared pin
	output logic             irq           // level interrupt
);
	logic [`HBC_CTRL_W-1:0] ctrl_reg;
	logic [PW-1:0]          duty_reg;
	logic [PW-1:0]          period_reg;
	logic [PW-1:0]          cnt_reg;
	logic [`HBC_ST_W-1:0]   status_reg;
	logic [`HBC_ST_W-1:0]   irq_en_reg;
	logic                   warn_d_reg;
	logic                   mod_reg;
	hbc_pins_s              want;
	hbc_pins_s              pins;

	wire access   = psel && penable;
	wire wr       = access && pwrite;
	wire en       = ctrl_reg[`HBC_CTRL_EN];
	wire anti     = ctrl_reg[`HBC_CTRL_MODE];
	wire brake_on = ctrl_reg[`HBC_CTRL_BRAKE];
	wire coast_on = ctrl_reg[`HBC_CTRL_COAST];
	wire addr_ok  = paddr == `HBC_OFF_CTRL || paddr == `HBC_OFF_DUTY || paddr == `HBC_OFF_PERIOD ||
	                paddr == `HBC_OFF_STATUS || paddr == `HBC_OFF_IRQ_EN || paddr == `HBC_OFF_IRQ_CLR ||
	                paddr == `HBC_OFF_PINS;

	// control registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg   <= '0;
			duty_reg   <= PW'(`HBC_DUTY_RST);
			period_reg <= PW'(`HBC_PERIOD_RST);
			irq_en_reg <= '0;
		end else if (wr) begin
			case (paddr)
				`HBC_OFF_CTRL:   ctrl_reg   <= pwdata[`HBC_CTRL_W-1:0];
				`HBC_OFF_DUTY:   duty_reg   <= pwdata[PW-1:0];
				`HBC_OFF_PERIOD: period_reg <= pwdata[PW-1:0];
				`HBC_OFF_IRQ_EN: irq_en_reg <= pwdata[`HBC_ST_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// apb answer: zero wait states, read data registered at the end of the setup cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable && !pready;
			pslverr <= psel && !penable && !addr_ok;
			prdata  <= '0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`HBC_OFF_CTRL:   prdata <= 32'(ctrl_reg);
					`HBC_OFF_DUTY:   prdata <= 32'(duty_reg);
					`HBC_OFF_PERIOD: prdata <= 32'(period_reg);
					`HBC_OFF_STATUS: prdata <= 32'(status_reg);
					`HBC_OFF_IRQ_EN: prdata <= 32'(irq_en_reg);
					`HBC_OFF_PINS:   prdata <= {28'h0000000, !warn_n_in, pins};
					default:         prdata <= '0;
				endcase
			end
		end
	end

	// period counter and comparator
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
			mod_reg <= 1'b0;
		end else begin
			cnt_reg <= (cnt_reg >= period_reg - PW'(1)) ? '0 : cnt_reg + PW'(1);
			mod_reg <= cnt_reg < duty_reg;
		end
	end

	// wanted pin levels; the separator spaces the edges
	// limitation: a pwm period shorter than about 2 us of edges gets stretched by the spacer
	always_comb begin
		want = '0;
		if (!en) begin
			want = '0;
		end else if (coast_on) begin
			want.brake = 1'b1; // pwm low with brake: all switches off
			want.pwm   = 1'b0;
			want.dir   = ctrl_reg[`HBC_CTRL_SIGN];
		end else if (brake_on) begin
			want.brake = 1'b1;
			want.pwm   = 1'b1;
			want.dir   = ctrl_reg[`HBC_CTRL_SIGN]; // high: high-side pair
		end else if (anti) begin
			want.pwm = 1'b1;
			want.dir = mod_reg; // duty of half period means zero drive
		end else begin
			want.dir = ctrl_reg[`HBC_CTRL_SIGN];
			want.pwm = mod_reg;                  // zero duty leaves pwm steady low
		end
	end

	hbc_sep #(
		.SEP_CYC(`HBC_SEP_CYC)
	) u_sep (
		.mclk    (mclk),
		.resetn  (resetn),
		.want    (want),
		.safe    ('0),
		.pins_reg(pins)
	);

	// pins registered once more so each output leaves a flip-flop in this module
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			drv_pwm    <= 1'b0;
			drv_dir    <= 1'b0;
			drv_brake  <= 1'b0;
			warn_n_out <= 1'b1;
			warn_n_oe  <= 1'b0;
		end else begin
			drv_pwm    <= pins.pwm;
			drv_dir    <= pins.dir;
			drv_brake  <= pins.brake;
			warn_n_out <= 1'b1;
			warn_n_oe  <= 1'b0; // wired-or pin is the drivers' only
		end
	end

	// warning events: falling edge sets warn, rising sets warn-cleared; set beats clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			warn_d_reg <= 1'b1;
			status_reg <= '0;
			irq        <= 1'b0;
		end else begin
			warn_d_reg <= warn_n_in;
			status_reg[`HBC_ST_WARN] <= (warn_d_reg && !warn_n_in) ||
				(status_reg[`HBC_ST_WARN] && !(wr && paddr == `HBC_OFF_IRQ_CLR && pwdata[`HBC_ST_WARN]));
			status_reg[`HBC_ST_WARN_CLR] <= (!warn_d_reg && warn_n_in) ||
				(status_reg[`HBC_ST_WARN_CLR] && !(wr && paddr == `HBC_OFF_IRQ_CLR && pwdata[`HBC_ST_WARN_CLR]));
			irq <= |(status_reg & irq_en_reg);
		end
	end
endmodule

// file: hbc_top_asserts.sv
// checker of the h-bridge controller pin timing and apb answer
// assumes binding to hbc_top; sees its ports only
`timescale 1ns/10ps
module hbc_top_asserts
	import hbc_pkg::*;
(
	input wire logic        mclk,      // clock
	input wire logic        resetn,    // async reset, active low
	input wire logic        psel,      // apb select
	input wire logic        penable,   // apb access
	input wire logic        pwrite,    // apb direction
	input wire logic [11:0] paddr,     // apb address
	input wire logic [31:0] pwdata,    // apb write data
	input wire logic        pready,    // apb ready
	input wire logic        drv_pwm,   // pwm pin
	input wire logic        drv_dir,   // direction pin
	input wire logic        drv_brake  // brake pin
);
	logic [2:0] prev_reg;
	logic [5:0] gap_reg;
	logic [4:0] ctrl_reg;
	wire  [2:0] pins = {drv_pwm, drv_dir, drv_brake};
	wire        chg  = pins != prev_reg;
	wire        run  = ctrl_reg[0] & ~ctrl_reg[3] & ~ctrl_reg[4];

	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	// saturates so the first edge after reset is never flagged
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prev_reg <= 3'h0;
			gap_reg <= 6'h3F;
		end else begin
			prev_reg <= pins;
			gap_reg <= chg ? 6'h00 : (gap_reg == 6'h3F ? gap_reg : gap_reg + 6'h01);
		end
	end

	// shadow of the control word, taken where the write lands
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			ctrl_reg <= 5'h00;
		else if (psel & penable & pready & pwrite & (paddr == 12'h000))
			ctrl_reg <= pwdata[4:0];
	end

	pin_spacing_a: assert property (chg |-> gap_reg >= 6'h27)
		else $error("pin edges closer than 40 cycles");
	single_edge_a: assert property ($onehot0(pins ^ prev_reg))
		else $error("two pins changed together");
	anti_pwm_a: assert property (run & ctrl_reg[1] & drv_pwm |=> drv_pwm)
		else $error("pwm pin left high level in anti-phase");
	sign_dir_a: assert property (run & ~ctrl_reg[1] & (drv_dir != ctrl_reg[2])
		|-> ##[1:130] (drv_dir == ctrl_reg[2] || !run || ctrl_reg[1]))
		else $error("direction pin does not follow sign");
	brake_pwm_a: assert property (run == 1'b0 && ctrl_reg[0] & ctrl_reg[3] & ~ctrl_reg[4] & drv_brake
		|-> ##[0:90] drv_pwm)
		else $error("brake without pwm high");
	apb_ready_a: assert property (psel & ~penable |=> pready)
		else $error("apb answer not in access cycle");
endmodule

// file: hbc_dev_model.sv
// behavioural h-bridge driver logic seen from its three input pins
// assumes faults come as levels; retry is faster than any bench cycle
`timescale 1ns/10ps
module hbc_dev_model
	import hbc_pkg::*;
(
	input  wire hbc_pins_s pins,    // pins from controller
	input  wire logic      hot,     // above warning temperature
	input  wire logic      shut,    // above shutdown temperature
	input  wire logic      oc,      // high-side overload
	output logic [3:0]     sw,      // {src1, snk1, src2, snk2}
	output logic           flag_oe  // pulls shared warning pin low
);
	logic off;
	assign off = shut | oc;
	// source and sink of one leg are exclusive by construction
	assign sw[3] = ~off & (pins.pwm ? pins.dir : ~pins.brake);
	assign sw[2] = ~off & pins.pwm & ~pins.dir;
	assign sw[1] = ~off & (pins.pwm ? pins.brake ~^ pins.dir : ~pins.brake);
	assign sw[0] = ~off & pins.pwm & (pins.brake ^ pins.dir);
	assign flag_oe = hot;
endmodule

// file: hbc_top_tb_top.sv
// testbench of the h-bridge controller driving a device model
// assumes hbc_pkg, hbc_top, hbc_dev_model and hbc_top_asserts compiled first
`timescale 1ns/10ps
module hbc_top_tb_top;
	import hbc_pkg::*;
	logic        mclk, resetn, psel, penable, pwrite, hot, shut, oc, sgn;
	logic        pready, pslverr, drv_pwm, drv_dir, drv_brake, warn_n_out, warn_n_oe, irq, flag_oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  sw;
	logic        warn_n_in;
	logic [32:0] expq[$];
	int          fails, n_tests;

	assign warn_n_in = ~(flag_oe | (warn_n_oe & ~warn_n_out)); // pull-up

	hbc_top u_hbc_top (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.drv_pwm(drv_pwm), .drv_dir(drv_dir), .drv_brake(drv_brake), .warn_n_in(warn_n_in),
		.warn_n_out(warn_n_out), .warn_n_oe(warn_n_oe), .irq(irq));
	hbc_dev_model u_hbc_dev_model (.pins({drv_pwm, drv_dir, drv_brake}), .hot(hot), .shut(shut),
		.oc(oc), .sw(sw), .flag_oe(flag_oe));

	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// read results are noted here and checked by the monitor below
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		n = 0;
		if (!w)
			expq.push_back(e);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			fails++;
			report_and_stop();
		end
		@(posedge mclk);
	endtask

	always @(posedge mclk)
		if (pready === 1'h1 && pwrite === 1'h0)
			chk({pslverr, prdata}, expq.pop_front());

	initial begin
		{psel, penable, pwrite, hot, shut, oc} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		resetn = 1'h0;
		fails = 0;
		n_tests = 0;
		sgn = 1'($urandom(91156));
		tick(2);
		resetn <= 1'h1;
		tick(1);
		apb(1'h0, 12'h004, 32'h0, 33'h1F4);
		apb(1'h0, 12'h008, 32'h0, 33'h3E8);
		apb(1'h0, 12'h01C, 32'h0, 33'h100000000);
		$display("register test done");
		for (int s = 0; s < 2; s++) begin
			apb(1'h1, 12'h000, 32'h9 | (s << 2), 33'h0);
			tick(150);
			chk(33'(sw), s ? 33'hA : 33'h5);
		end
		apb(1'h1, 12'h000, 32'h11, 33'h0);
		tick(150);
		chk(33'(sw), 33'h0);
		$display("brake test done");
		apb(1'h1, 12'h004, 32'h0, 33'h0);
		apb(1'h1, 12'h000, 32'h1 | (sgn << 2), 33'h0);
		tick(150);
		chk(33'(sw), 33'hA);
		apb(1'h1, 12'h004, 32'h3E8, 33'h0);
		tick(150);
		chk(33'(sw), sgn ? 33'h9 : 33'h6);
		$display("sign test done");
		apb(1'h1, 12'h000, 32'h3, 33'h0);
		tick(2500);
		chk(33'(drv_pwm), 33'h1);
		apb(1'h1, 12'h000, 32'h1 | (sgn << 2), 33'h0);
		tick(150);
		$display("anti-phase test done");
		for (int f = 0; f < 2; f++) begin
			{shut, oc} <= f ? 2'h1 : 2'h2;
			tick(2);
			chk(33'(sw), 33'h0);
			{shut, oc} <= 2'h0;
			tick(2);
			chk(33'(sw), sgn ? 33'h9 : 33'h6);
		end
		$display("fault test done");
		apb(1'h1, 12'h010, 32'h1, 33'h0);
		hot <= 1'h1;
		tick(5);
		chk(33'(irq), 33'h1);
		chk(33'(sw), sgn ? 33'h9 : 33'h6);
		hot <= 1'h0;
		tick(5);
		apb(1'h0, 12'h00C, 32'h0, 33'h3);
		apb(1'h1, 12'h014, 32'h3, 33'h0);
		apb(1'h0, 12'h00C, 32'h0, 33'h0);
		chk(33'(irq), 33'h0);
		apb(1'h1, 12'h010, 32'h0, 33'h0);
		hot <= 1'h1;
		tick(5);
		chk(33'(irq), 33'h0);
		chk(33'({warn_n_out, warn_n_oe}), 33'h2);
		apb(1'h0, 12'h018, 32'h0, 33'hC | 33'(sgn << 1));
		apb(1'h0, 12'h000, 32'h0, 33'h1 | 33'(sgn << 2));
		$display("interrupt test done");
		report_and_stop();
	end
endmodule

bind hbc_top hbc_top_asserts u_hbc_top_asserts (.mclk(mclk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.drv_pwm(drv_pwm), .drv_dir(drv_dir), .drv_brake(drv_brake));
